/* include/mgmt_pkg.sv */
/*
 file: constants for the management register bank, address map,
 per-bit access masks, default values and field positions.
 assumes: included before any design file that imports it.
*/
package mgmt_pkg;
   // register addresses on the 5-bit management address field
   localparam logic [4:0] ADDR_BASIC_CONTROL = 5'h00;
   localparam logic [4:0] ADDR_BASIC_STATUS = 5'h01;
   localparam logic [4:0] ADDR_ID_HIGH = 5'h02;
   localparam logic [4:0] ADDR_ID_LOW = 5'h03;
   localparam logic [4:0] ADDR_NEG_ADVERTISE = 5'h04;
   localparam logic [4:0] ADDR_PARTNER_ABILITY = 5'h05;
   localparam logic [4:0] ADDR_NEG_EXPANSION = 5'h06;
   localparam logic [4:0] ADDR_NEXT_PAGE_TX = 5'h07;
   localparam logic [4:0] ADDR_PARTNER_NEXT_PAGE = 5'h08;
   localparam logic [4:0] ADDR_STD_RESERVED_LO = 5'h09;
   localparam logic [4:0] ADDR_EXTENDED_CONTROL = 5'h10;
   localparam logic [4:0] ADDR_DETAILED_POLL = 5'h11;
   localparam logic [4:0] ADDR_TEN_MB_OPS = 5'h12;
   localparam logic [4:0] ADDR_SECOND_ADVERTISE = 5'h13;
   localparam logic [4:0] ADDR_VENDOR_RESERVED_LO = 5'h14;
   // word count, and storage index of the words the bank names
   localparam int NUM_WORDS = 13;
   localparam logic [3:0] IDX_BASIC_CONTROL = 4'h0;
   localparam logic [3:0] IDX_BASIC_STATUS = 4'h1;
   localparam logic [3:0] IDX_ID_HIGH = 4'h2;
   localparam logic [3:0] IDX_NEG_EXPANSION = 4'h6;
   localparam logic [3:0] IDX_EXTENDED_CONTROL = 4'h9;
   localparam logic [3:0] IDX_DETAILED_POLL = 4'ha;
   localparam logic [3:0] IDX_TEN_MB_OPS = 4'hb;
   // field positions and fixed data words
   localparam int OVERRIDE_BIT = 15;
   localparam int ISOLATE_BIT = 10;
   localparam int PREAMBLE_BIT = 6;
   localparam int PHYAD_LSB = 6;
   localparam int PHYAD_MSB = 10;
   localparam int EXPANSION_FAULT_BIT = 4;
   localparam int TEN_MB_FAULT_BIT = 15;
   localparam logic [15:0] UNMAPPED_DATA = 16'hffff;
   localparam logic [15:0] ZERO_WORD = 16'h0000;
   // identifier words, values are arbitrary
   localparam logic [15:0] ID_HIGH_VALUE = 16'h0a5a;
   localparam logic [15:0] ID_LOW_VALUE = 16'h5a50;
   typedef logic [15:0] word_tab_t [NUM_WORDS];
   // defaults before strapped bits are merged in
   localparam word_tab_t RST_TAB = '{16'h3000, 16'h7809, ID_HIGH_VALUE,
      ID_LOW_VALUE, 16'h01e1, 16'h0000, 16'h0004, 16'h2001, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000};
   // read/write bits
   localparam word_tab_t RW_TAB = '{16'hff80, 16'h0000, 16'h0000,
      16'h0000, 16'h3fe0, 16'h0000, 16'h0000, 16'hb7ff, 16'h0000,
      16'h0030, 16'h0000, 16'h003f, 16'h0003};
   // write-zero-only bits
   localparam word_tab_t W0_TAB = '{16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0010, 16'h0000, 16'h0000,
      16'h0000, 16'h0003, 16'h8000, 16'h0000};
   // override-gated bits
   localparam word_tab_t CW_TAB = '{16'h0000, 16'h0040, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h07c0, 16'h0000, 16'h0000, 16'h0004};
   // read-only bits that follow live hardware state
   localparam word_tab_t HW_TAB = '{16'h0000, 16'h0036, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'hfff0, 16'h0000, 16'h0000};
endpackage : mgmt_pkg

/* rtl/mgmt_reg_word.sv */
/*
 file: one 16-bit management word with per-bit access types.
 assumes: the caller gives a one-cycle write strobe and holds the
 default value valid while reset is low.
*/
`timescale 1ns/1ns
module mgmt_reg_word #(
   parameter logic [15:0] RW_M = 16'h0000,
   parameter logic [15:0] W0_M = 16'h0000,
   parameter logic [15:0] CW_M = 16'h0000,
   parameter logic [15:0] HW_M = 16'h0000
) (
   input wire logic clock_in,            // system clock
   input wire logic rst_n_in,            // sync reset, active low
   input wire logic [15:0] rst_val_in,   // default value
   input wire logic wr_in,               // write strobe
   input wire logic unlock_in,           // override armed
   input wire logic [15:0] wdata_in,     // write data
   input wire logic [15:0] hw_val_in,    // live read-only state
   input wire logic [15:0] set_in,       // hardware set of w0 bits
   output logic [15:0] q_out             // stored word
);
   logic [15:0] q_r;
   logic [15:0] q_nxt;
   wire logic [15:0] keep_m = ~(RW_M | W0_M | CW_M | HW_M);
   // each access type is merged bit by bit
   wire logic [15:0] rw_part = (wr_in ? wdata_in : q_r) & RW_M;
   wire logic [15:0] w0_part =
      (((wr_in ? (q_r & wdata_in) : q_r)) | set_in) & W0_M;
   wire logic [15:0] cw_part =
      ((wr_in && unlock_in) ? wdata_in : q_r) & CW_M;
   wire logic [15:0] hw_part = hw_val_in & HW_M;
   wire logic [15:0] ro_part = q_r & keep_m;
   assign q_nxt = rw_part | w0_part | cw_part | hw_part | ro_part;
   assign q_out = q_r;

   // storage, default loaded while reset is held
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         q_r <= rst_val_in;
      end else begin
         q_r <= q_nxt;
      end
   end
endmodule : mgmt_reg_word

/* rtl/phy_mgmt_register_bank.sv */
/*
 file: management register bank, address decode, override unlock,
 strapped defaults and read data return.
 assumes: the frame engine gives one-cycle access strobes with a
 5-bit address and 16-bit data, msb sent first on the wire.
*/
// Functional notes
// - addresses 0..8 are the standard words, 9..15 reserved.
// - addresses 16..19 are vendor words, 20..31 reserved.
// - read-only bits read their value and ignore writes.
// - gated bits always read, writes ignored while unlock is 0.
// - with unlock set the next write may change gated bits.
// - unlock clears itself when that next write completes.
// - read/write bits store any write and read it back.
// - write-zero-only bits read freely and take only a zero.
// - every bit with a default takes it on any reset.
// - strapped phy address bits take the pin levels seen during reset; isolate is set when all pins are low.
// - every word is 16 bits, msb first on the wire.
// - reading an unmapped address returns all ones.
// - writing an unmapped address changes no stored word, but spends an armed unlock.
`timescale 1ns/1ns
module phy_mgmt_register_bank (
   input wire logic clock_in,                  // 100 MHz clock
   input wire logic rst_n_in,                  // sync reset, low
   input wire logic acc_valid_in,              // access strobe
   input wire logic acc_write_in,              // 1 write, 0 read
   input wire logic [4:0] acc_addr_in,         // register address
   input wire logic [15:0] acc_wdata_in,       // write data
   input wire logic strap_pin_bit0_in,         // strap pin 0
   input wire logic strap_pin_bit1_in,         // strap pin 1
   input wire logic strap_pin_bit2_in,         // strap pin 2
   input wire logic strap_pin_bit3_in,         // strap pin 3
   input wire logic strap_pin_bit4_in,         // strap pin 4
   input wire logic [15:0] status_in,          // live basic status
   input wire logic [15:0] detail_in,          // live detailed status
   input wire logic [3:0] event_in,            // fault event pulses
   output logic acc_done_out,                  // access answered
   output logic [15:0] rd_data_out,            // read data
   output logic [15:0] control_out,            // basic control word
   output logic [mgmt_pkg::PHYAD_MSB-mgmt_pkg::PHYAD_LSB:0]
      phy_addr_out,                            // stored phy address
   output logic override_out                   // unlock armed
);
   import mgmt_pkg::*;

   logic [15:0] word_q [NUM_WORDS];
   logic [15:0] rst_val [NUM_WORDS];
   logic [15:0] hw_val [NUM_WORDS];
   logic [15:0] set_val [NUM_WORDS];
   logic override_r;
   logic override_nxt;
   logic done_r;
   logic [15:0] rd_data_r;
   logic [15:0] rd_data_nxt;

   // strap pins gathered into the phy address field
   wire logic [4:0] strap_bus = {strap_pin_bit4_in, strap_pin_bit3_in,
      strap_pin_bit2_in, strap_pin_bit1_in, strap_pin_bit0_in};
   wire logic strap_zero = (strap_bus == 5'h00);

   // address decode into standard and vendor ranges
   wire logic hit_std = (acc_addr_in < ADDR_STD_RESERVED_LO);
   wire logic hit_vendor = (acc_addr_in >= ADDR_EXTENDED_CONTROL) &&
      (acc_addr_in < ADDR_VENDOR_RESERVED_LO);
   wire logic hit = hit_std || hit_vendor;
   wire logic [3:0] vendor_idx =
      IDX_EXTENDED_CONTROL + {2'b00, acc_addr_in[1:0]};
   wire logic [3:0] idx = hit_std ? acc_addr_in[3:0] : vendor_idx;

   // access strobes
   wire logic wr_any = acc_valid_in && acc_write_in;
   wire logic wr_hit = wr_any && hit;
   wire logic rd_any = acc_valid_in && !acc_write_in;

   // unlock: set by a write of one, spent by the following write
   wire logic arm_req = wr_hit && (idx == IDX_EXTENDED_CONTROL) &&
      acc_wdata_in[OVERRIDE_BIT];
   assign override_nxt = wr_any ? (!override_r && arm_req)
                                : override_r;

   // default values, strapped fields merged while reset is held
   always_comb begin
      for (int i = 0; i < NUM_WORDS; i++) begin
         rst_val[i] = RST_TAB[i];
      end
      rst_val[IDX_BASIC_CONTROL][ISOLATE_BIT] = strap_zero;
      rst_val[IDX_EXTENDED_CONTROL][PHYAD_MSB:PHYAD_LSB] =
         strap_bus;
   end

   // live hardware state feeding read-only bits
   always_comb begin
      for (int i = 0; i < NUM_WORDS; i++) begin
         hw_val[i] = ZERO_WORD;
      end
      hw_val[IDX_BASIC_STATUS] = status_in;
      hw_val[IDX_DETAILED_POLL] = detail_in;
   end

   // hardware events that set write-zero-only bits
   always_comb begin
      for (int i = 0; i < NUM_WORDS; i++) begin
         set_val[i] = ZERO_WORD;
      end
      set_val[IDX_NEG_EXPANSION][EXPANSION_FAULT_BIT] = event_in[0];
      set_val[IDX_DETAILED_POLL][1:0] = event_in[2:1];
      set_val[IDX_TEN_MB_OPS][TEN_MB_FAULT_BIT] = event_in[3];
   end

   // one storage word per implemented address
   for (genvar g = 0; g < NUM_WORDS; g++) begin : gen_word
      localparam logic [3:0] GIDX = 4'(g);
      mgmt_reg_word #(
         .RW_M(RW_TAB[g]),
         .W0_M(W0_TAB[g]),
         .CW_M(CW_TAB[g]),
         .HW_M(HW_TAB[g])
      ) u_word (
         .clock_in(clock_in),
         .rst_n_in(rst_n_in),
         .rst_val_in(rst_val[g]),
         .wr_in(wr_hit && (idx == GIDX)),
         .unlock_in(override_r),
         .wdata_in(acc_wdata_in),
         .hw_val_in(hw_val[g]),
         .set_in(set_val[g]),
         .q_out(word_q[g])
      );
   end

   // read mux, unlock shown in the extended control word
   wire logic [15:0] sel_word = word_q[idx];
   wire logic [15:0] ext_view =
      sel_word | (16'(override_r) << OVERRIDE_BIT);
   wire logic is_ext = (idx == IDX_EXTENDED_CONTROL);
   assign rd_data_nxt = !hit ? UNMAPPED_DATA :
                        is_ext ? ext_view : sel_word;

   // unlock flag
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         override_r <= 1'b0;
      end else begin
         override_r <= override_nxt;
      end
   end

   // answer strobe and read data, one cycle after the access
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         done_r <= 1'b0;
         rd_data_r <= ZERO_WORD;
      end else begin
         done_r <= acc_valid_in;
         if (rd_any) begin
            rd_data_r <= rd_data_nxt;
         end
      end
   end

   // outputs straight from flops
   assign acc_done_out = done_r;
   assign rd_data_out = rd_data_r;
   assign control_out = word_q[IDX_BASIC_CONTROL];
   assign phy_addr_out =
      word_q[IDX_EXTENDED_CONTROL][PHYAD_MSB:PHYAD_LSB];
   assign override_out = override_r;

   // helper views for the checks below
   wire logic wr_ctrl = wr_any && (acc_addr_in == ADDR_BASIC_CONTROL);
   wire logic wr_stat = wr_any && (acc_addr_in == ADDR_BASIC_STATUS);
   wire logic wr_id = wr_any && (acc_addr_in == ADDR_ID_HIGH);
   wire logic wr_ten = wr_any && (acc_addr_in == ADDR_TEN_MB_OPS);
   wire logic wr_ext = wr_any && (acc_addr_in == ADDR_EXTENDED_CONTROL);
   wire logic [15:0] ctrl_w = word_q[IDX_BASIC_CONTROL];
   wire logic [15:0] stat_w = word_q[IDX_BASIC_STATUS];
   wire logic [15:0] ext_w = word_q[IDX_EXTENDED_CONTROL];
   wire logic [15:0] ten_w = word_q[IDX_TEN_MB_OPS];
   wire logic [15:0] id_w = word_q[IDX_ID_HIGH];
   wire logic wr_det = wr_any && (acc_addr_in == ADDR_DETAILED_POLL);
   wire logic wr_adv = wr_any && (acc_addr_in == ADDR_NEG_ADVERTISE);
   wire logic [15:0] det_w = word_q[IDX_DETAILED_POLL];
   wire logic [15:0] exp_w = word_q[IDX_NEG_EXPANSION];
   wire logic [15:0] adv_w = word_q[ADDR_NEG_ADVERTISE[3:0]];
   wire logic [15:0] adv_m = RW_TAB[ADDR_NEG_ADVERTISE[3:0]];
   wire logic [15:0] stat_m = HW_TAB[IDX_BASIC_STATUS];
   wire logic [15:0] det_m = HW_TAB[IDX_DETAILED_POLL];

   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_n_in);

   // arming and spending the unlock in two steps
   sequence s_arm;
      wr_ext && !override_r && acc_wdata_in[OVERRIDE_BIT];
   endsequence

   sequence s_gated_write;
      wr_stat && acc_wdata_in[PREAMBLE_BIT];
   endsequence

   // read of an unmapped address returns all ones
   a_unmapped_read: assert property (
      rd_any && !hit |=> acc_done_out && (rd_data_out == 16'hffff))
      else $error("unmapped read did not return all ones");

   // every access is answered exactly one cycle later
   a_done_timing: assert property (
      acc_valid_in |=> acc_done_out ##1 (acc_done_out == $past(acc_valid_in)))
      else $error("access answer strobe mistimed");

   // a write while armed leaves the unlock cleared
   a_override_spent: assert property (
      wr_any && override_r |=> !override_r)
      else $error("unlock survived the following write");

   // armed gated write sets the gated status bit and spends the unlock
   a_override_unlock: assert property (
      override_r ##0 s_gated_write |=> stat_w[PREAMBLE_BIT] && !override_r)
      else $error("armed write did not reach gated bit");

   // a write of the unlock bit arms it for the next write
   a_override_arm: assert property (
      s_arm |=> override_r)
      else $error("unlock not armed by write");

   // gated bit holds while unlock is clear
   a_gated_locked: assert property (
      wr_stat && !override_r |=>
      stat_w[PREAMBLE_BIT] == $past(stat_w[PREAMBLE_BIT]))
      else $error("gated bit changed without unlock");

   // read/write bits take the written value
   a_rw_store: assert property (
      wr_ctrl |=> ctrl_w[15:7] == $past(acc_wdata_in[15:7]))
      else $error("read/write bits did not store write");

   // mixed word keeps its read-only part on write
   a_mixed_keep: assert property (
      wr_ctrl |=> ctrl_w[6:0] == $past(ctrl_w[6:0]))
      else $error("read-only part of control word changed");

   // write-zero-only bit never set by software
   a_w0_clear_only: assert property (
      wr_ten && !event_in[3] |=>
      ten_w[15] == ($past(ten_w[15]) && $past(acc_wdata_in[15])))
      else $error("write-zero-only bit took a one");

   // hardware set beats a simultaneous clear
   a_w0_set_wins: assert property (
      event_in[3] |=> ten_w[15])
      else $error("fault event lost");

   // identifier word is constant
   a_ro_ignore: assert property (
      wr_id |=> id_w == $past(id_w))
      else $error("read-only word changed on write");

   // unmapped write disturbs neither the basic control nor the extended control word
   a_unmapped_write: assert property (
      wr_any && !hit |=> $stable(ctrl_w) && $stable(ext_w))
      else $error("unmapped write changed a register");

   // reserved range never decodes as implemented
   a_reserved_decode: assert property (
      acc_addr_in >= ADDR_VENDOR_RESERVED_LO |-> !hit)
      else $error("vendor reserved address decoded");

   // standard reserved range never decodes
   a_std_reserved: assert property (
      (acc_addr_in >= ADDR_STD_RESERVED_LO) &&
      (acc_addr_in < ADDR_EXTENDED_CONTROL) |-> !hit)
      else $error("standard reserved address decoded");

   // reset loads defaults and strapped address
   a_reset_defaults: assert property (
      @(posedge clock_in) disable iff (1'b0)
      !rst_n_in |=> ctrl_w[15:11] == RST_TAB[0][15:11] && !override_r)
      else $error("default not loaded by reset");

   a_strap_capture: assert property (
      @(posedge clock_in) disable iff (1'b0)
      !rst_n_in |=> (ext_w[PHYAD_MSB:PHYAD_LSB] == $past(strap_bus)) &&
      (ctrl_w[ISOLATE_BIT] == ($past(strap_bus) == 5'h00)))
      else $error("strap level not captured at reset");

   // reads leave an armed unlock in place
   a_read_keeps_unlock: assert property (
      rd_any && override_r |=> override_r)
      else $error("read spent the unlock");

   // phy address field locked while unlock is clear
   a_phyad_locked: assert property (
      wr_ext && !override_r |=>
      ext_w[PHYAD_MSB:PHYAD_LSB] == $past(ext_w[PHYAD_MSB:PHYAD_LSB]))
      else $error("gated address changed without unlock");

   // armed write to the extended word reaches the address field
   a_phyad_open: assert property (
      wr_ext && override_r |=>
      ext_w[PHYAD_MSB:PHYAD_LSB] == $past(acc_wdata_in[PHYAD_MSB:PHYAD_LSB]))
      else $error("armed write missed the address field");

   // read data holds between reads
   a_read_hold: assert property (
      !rd_any |=> $stable(rd_data_out))
      else $error("read data moved without a read");

   // live status bits follow their inputs one cycle late
   a_status_follow: assert property (
      acc_valid_in |=> (stat_w & stat_m) == ($past(status_in) & stat_m))
      else $error("live status bits did not follow input");

   // live detail bits follow their inputs one cycle late
   a_detail_follow: assert property (
      acc_valid_in |=> (det_w & det_m) == ($past(detail_in) & det_m))
      else $error("live detail bits did not follow input");

   // write-zero-only detail bits take no ones
   a_w0_detail: assert property (
      wr_det && (event_in[2:1] == 2'b00) |=>
      det_w[1:0] == ($past(det_w[1:0]) & $past(acc_wdata_in[1:0])))
      else $error("write-zero-only detail bit took a one");

   // expansion fault event sets its bit
   a_w0_event_set: assert property (
      event_in[0] |=> exp_w[EXPANSION_FAULT_BIT])
      else $error("expansion fault event lost");

   // read/write advertise bits store the written value
   a_rw_advertise: assert property (
      wr_adv |=> (adv_w & adv_m) == ($past(acc_wdata_in) & adv_m))
      else $error("advertise bits did not store write");

   // identifier word read through the standard decode
   a_std_read: assert property (
      rd_any && (acc_addr_in == ADDR_ID_HIGH) |=>
      rd_data_out == ID_HIGH_VALUE)
      else $error("identifier word read wrongly");

   // vendor word read through the vendor decode
   a_vendor_read: assert property (
      rd_any && (acc_addr_in == ADDR_TEN_MB_OPS) |=>
      rd_data_out == $past(ten_w))
      else $error("vendor word read wrongly");

   // unlock shows in bit 15 of the extended word on a read
   a_ext_read: assert property (
      rd_any && (acc_addr_in == ADDR_EXTENDED_CONTROL) |=>
      rd_data_out[OVERRIDE_BIT] == $past(override_r))
      else $error("unlock bit read wrongly");

endmodule : phy_mgmt_register_bank

/* verif/sta_model.sv */
/*
 station management model: issues reads and writes on the bank's
 access port, one whole 16-bit word per access.
 assumes: the bank answers with acc_done_out one cycle after the strobe.
*/
`timescale 1ns/1ns
module sta_model (
   input wire logic clock_in,           // system clock
   input wire logic acc_done_in,        // access answered
   input wire logic [15:0] rd_data_in,  // read data
   output logic acc_valid_out,          // access strobe
   output logic acc_write_out,          // 1 write, 0 read
   output logic [4:0] acc_addr_out,     // register address
   output logic [15:0] acc_wdata_out    // write data
);
   int miss_count = 0;
   // idle port at time zero
   initial begin
      acc_valid_out = 1'b0;
      acc_write_out = 1'b0;
      acc_addr_out = 5'h00;
      acc_wdata_out = 16'h0000;
   end
   // one access: strobe for one cycle, bounded wait for the answer
   task automatic access(input logic wr, input logic [4:0] addr,
      input logic [15:0] wdata, output logic [15:0] rdata);
      int n;
      n = 0;
      @(negedge clock_in);
      acc_valid_out = 1'b1;
      acc_write_out = wr;
      acc_addr_out = addr;
      acc_wdata_out = wdata; // whole word per access
      @(negedge clock_in);
      // released lines show the inverse so stale values never match
      acc_valid_out = 1'b0;
      acc_write_out = ~wr;
      acc_addr_out = ~addr;
      acc_wdata_out = ~wdata;
      while (acc_done_in !== 1'b1 && n < 4) begin
         @(negedge clock_in);
         n++;
      end
      if (n == 4) begin
         miss_count++;
      end
      rdata = rd_data_in;
   endtask : access
endmodule : sta_model

/* verif/tb.sv */
/*
 testbench for the management register bank: register accesses
 through the station model, compared with values worked out here.
 assumes: mgmt_pkg compiled first; inputs change at falling edges.
*/
`timescale 1ns/1ns
`define CHECK(got, exp) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) begin \
         bad_count++; \
         $display("Error at %0t: got %h expected %h", $time, got, exp); \
      end \
   end
module tb;
   import mgmt_pkg::*;
   logic clock_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [4:0] strap = 5'h00;
   logic [15:0] status_in = 16'h0000;
   logic [15:0] detail_in = 16'h0000;
   logic [3:0] event_in = 4'h0;
   logic acc_valid, acc_write, acc_done, override_out;
   logic [4:0] acc_addr, phy_addr_out;
   logic [15:0] acc_wdata, rd_data, control_out;
   int n_tests = 0;
   int bad_count = 0;
   // free-running 100 MHz clock
   always #5 clock_in = ~clock_in;
   phy_mgmt_register_bank u_dut (
      .clock_in(clock_in), .rst_n_in(rst_n_in),
      .acc_valid_in(acc_valid), .acc_write_in(acc_write),
      .acc_addr_in(acc_addr), .acc_wdata_in(acc_wdata),
      .strap_pin_bit0_in(strap[0]), .strap_pin_bit1_in(strap[1]),
      .strap_pin_bit2_in(strap[2]), .strap_pin_bit3_in(strap[3]),
      .strap_pin_bit4_in(strap[4]), .status_in(status_in),
      .detail_in(detail_in), .event_in(event_in),
      .acc_done_out(acc_done), .rd_data_out(rd_data),
      .control_out(control_out), .phy_addr_out(phy_addr_out),
      .override_out(override_out));
   sta_model u_sta (
      .clock_in(clock_in), .acc_done_in(acc_done),
      .rd_data_in(rd_data), .acc_valid_out(acc_valid),
      .acc_write_out(acc_write), .acc_addr_out(acc_addr),
      .acc_wdata_out(acc_wdata));
   // verdict and end of run
   task automatic conclude();
      bad_count += u_sta.miss_count;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      logic [15:0] r;
      u_sta.access(1'b1, a, d, r);
   endtask : wr
   task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
      logic [15:0] r;
      u_sta.access(1'b0, a, 16'h0000, r);
      `CHECK(r, e)
   endtask : rd_chk
   task automatic do_reset(input logic [4:0] s);
      @(negedge clock_in);
      rst_n_in = 1'b0;
      strap = s;
      repeat (2) @(negedge clock_in);
      rst_n_in = 1'b1;
   endtask : do_reset
   task automatic pulse(input int i);
      @(negedge clock_in);
      event_in[i] = 1'b1;
      @(negedge clock_in);
      event_in = 4'h0;
   endtask : pulse
   // expected default of each address with straps 5'h15
   function automatic logic [15:0] dflt(input int a);
      case (a)
         0: dflt = 16'h3000;
         1: dflt = 16'h7809;
         2: dflt = ID_HIGH_VALUE;
         3: dflt = ID_LOW_VALUE;
         4: dflt = 16'h01e1;
         6: dflt = 16'h0004;
         7: dflt = 16'h2001;
         5, 8, 17, 18, 19: dflt = 16'h0000;
         16: dflt = 16'h0540;
         default: dflt = UNMAPPED_DATA;
      endcase
   endfunction : dflt
   // watchdog at 20000 cycles, well beyond the expected 155 or so
   initial begin
      #200000;
      bad_count++;
      conclude();
   end
   // main sequence
   initial begin
      repeat (2) @(negedge clock_in);
      rst_n_in = 1'b1;
      `CHECK(control_out, 16'h3400)
      `CHECK(phy_addr_out, 5'h00)
      `CHECK(override_out, 1'b0)
      do_reset(5'h15);
      `CHECK(phy_addr_out, 5'h15)
      for (int a = 0; a < 32; a++) begin
         rd_chk(a[4:0], dflt(a));
      end
      // reserved low bits of word 0 written at their defaults
      wr(5'h00, 16'hff80);
      rd_chk(5'h00, 16'hff80);
      `CHECK(control_out, 16'hff80)
      wr(5'h00, 16'h3000);
      wr(5'h02, 16'hffff);
      rd_chk(5'h02, ID_HIGH_VALUE);
      wr(5'h01, 16'h7849);
      rd_chk(5'h01, 16'h7809);
      wr(5'h10, 16'h0030);
      rd_chk(5'h10, 16'h0570);
      wr(5'h10, 16'h8030);
      `CHECK(override_out, 1'b1)
      rd_chk(5'h10, 16'h8570);
      wr(5'h01, 16'h7849);
      `CHECK(override_out, 1'b0)
      rd_chk(5'h01, 16'h7849);
      wr(5'h01, 16'h7809);
      rd_chk(5'h01, 16'h7849);
      wr(5'h10, 16'h8030);
      wr(5'h10, 16'h07f0);
      `CHECK(phy_addr_out, 5'h1f)
      rd_chk(5'h10, 16'h07f0);
      // live read-only status bits follow the inputs
      @(negedge clock_in);
      status_in = 16'h0036;
      rd_chk(5'h01, 16'h787f);
      status_in = 16'h0000;
      pulse(0);
      rd_chk(5'h06, 16'h0014);
      wr(5'h06, 16'hffff);
      rd_chk(5'h06, 16'h0014);
      wr(5'h06, 16'h0000);
      rd_chk(5'h06, 16'h0004);
      pulse(3);
      rd_chk(5'h12, 16'h8000);
      wr(5'h12, 16'h003f);
      rd_chk(5'h12, 16'h003f);
      // detailed status: live bits plus two write-zero-only events
      detail_in = 16'habc0;
      pulse(1);
      pulse(2);
      rd_chk(5'h11, 16'habc3);
      wr(5'h11, 16'h0000);
      rd_chk(5'h11, 16'habc0);
      detail_in = 16'h0000;
      // unmapped write spends the unlock and changes nothing
      wr(5'h10, 16'h8030);
      wr(5'h14, 16'hffff);
      `CHECK(override_out, 1'b0)
      rd_chk(5'h14, UNMAPPED_DATA);
      wr(5'h01, 16'h7809);
      rd_chk(5'h01, 16'h7849);
      rd_chk(5'h00, 16'h3000);
      do_reset(5'h00);
      `CHECK(control_out, 16'h3400)
      rd_chk(5'h01, 16'h7809);
      conclude();
   end
endmodule : tb
